// ---- verilog/cfg_pkg.sv ----
package ccr_pkg;
  localparam logic [7:0] CCR_MODE_OFFSET     = 8'h9c;
  localparam logic [7:0] CCR_MUX_OFFSET      = 8'h9f;
  localparam logic [7:0] CCR_CTRL_OFFSET     = 8'h9a;
  localparam logic [7:0] CCR_IRQ_STAT_OFFSET = 8'ha0;
  localparam logic [7:0] CCR_IRQ_CLR_OFFSET  = 8'ha1;
  localparam logic [7:0] CCR_IRQ_EN_OFFSET   = 8'ha2;
  localparam logic [7:0] CCR_MODE_RESET      = 8'h02;
  localparam logic [7:0] CCR_MUX_RESET       = 8'h00;
  localparam logic [7:0] CCR_CTRL_RESET      = 8'h00;
  localparam logic [7:0] CCR_IRQ_EN_RESET    = 8'h00;
  localparam logic [7:0] CCR_MODE_MASK       = 8'h33;
  localparam logic [7:0] CCR_MUX_MASK        = 8'h33;
  localparam int         CCR_ON_BIT          = 7;
  localparam int         CCR_OUT_BIT         = 6;
  localparam int         CCR_RISE_BIT        = 5;
  localparam int         CCR_FALL_BIT        = 4;
  localparam int         CCR_INV_LSB         = 4;
  localparam int         CCR_NONINV_LSB      = 0;
  localparam int         CCR_SPEED_LSB       = 0;
  localparam int         CCR_MODE0_NS        = 100;
  localparam int         CCR_MODE3_NS        = 1050;
endpackage : ccr_pkg

// ---- verilog/ccr_comparator1_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccr_comparator1_config_regs
  import ccr_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       cmp_raw_in,
  output logic            comparator_on_out,
  output logic      [3:0] inverting_onehot_out,
  output logic      [3:0] noninverting_onehot_out,
  output logic      [1:0] response_speed_select_out,
  output logic            cmp_pin_out,
  output logic            irq_out,
  output logic            ext_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] mode_r;
  logic [7:0] mux_r;
  logic       on_r;
  logic [3:0] hyst_r;
  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic       rise_edge_flag_r;
  logic       fall_edge_flag_r;
  logic [1:0] stat_r;
  logic [1:0] irq_en_r;
  logic       rise_ev;
  logic       fall_ev;
  logic       wr_ctrl;
  logic       wr_clr;
  logic       wr_mode;
  logic       wr_mux;
  logic       wr_en;
  logic [7:0] rdata_nxt;

  // The analogue output is asynchronous, so it is synchronised first.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= cmp_raw_in;
      sync2_r <= sync1_r & on_r;
      prev_r  <= sync2_r;
    end
  end

  assign rise_ev = sync2_r & ~prev_r;
  assign fall_ev = ~sync2_r & prev_r;
  assign wr_ctrl = wr_in && (addr_in == CCR_CTRL_OFFSET);
  assign wr_clr  = wr_in && (addr_in == CCR_IRQ_CLR_OFFSET);
  assign wr_mode = wr_in && (addr_in == CCR_MODE_OFFSET);
  assign wr_mux  = wr_in && (addr_in == CCR_MUX_OFFSET);
  assign wr_en   = wr_in && (addr_in == CCR_IRQ_EN_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // Unused bit pairs are never stored, so a read returns them as zero
  // without any extra masking on the read path.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_r <= CCR_MODE_RESET;
    end else if (wr_mode) begin
      mode_r <= wdata_in & CCR_MODE_MASK;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mux_r <= CCR_MUX_RESET;
    end else if (wr_mux) begin
      mux_r <= wdata_in & CCR_MUX_MASK;
    end
  end

  // The control register keeps the enable and hysteresis bits here; its
  // flag bits live with the edge logic below.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      on_r   <= CCR_CTRL_RESET[CCR_ON_BIT];
      hyst_r <= CCR_CTRL_RESET[3:0];
    end else if (wr_ctrl) begin
      on_r   <= wdata_in[CCR_ON_BIT];
      hyst_r <= wdata_in[3:0];
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_en_r <= CCR_IRQ_EN_RESET[1:0];
    end else if (wr_en) begin
      irq_en_r <= wdata_in[1:0];
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rise_edge_flag_r <= 1'b0;
      fall_edge_flag_r <= 1'b0;
    end else begin
      if (rise_ev)
        rise_edge_flag_r <= 1'b1;
      else if (wr_ctrl && !wdata_in[CCR_RISE_BIT])
        rise_edge_flag_r <= 1'b0;
      if (fall_ev)
        fall_edge_flag_r <= 1'b1;
      else if (wr_ctrl && !wdata_in[CCR_FALL_BIT])
        fall_edge_flag_r <= 1'b0;
    end
  end

  // Sticky block-level status: bit 0 rising event, bit 1 falling event.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stat_r <= 2'h0;
    end else begin
      stat_r[0] <= rise_ev | (stat_r[0] & ~(wr_clr & wdata_in[0]));
      stat_r[1] <= fall_ev | (stat_r[1] & ~(wr_clr & wdata_in[1]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data are chosen here and registered, so they stand exactly one
  // cycle after the strobe and are zero in every other cycle.
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_in) begin
      case (addr_in)
        CCR_MODE_OFFSET:     rdata_nxt = mode_r;
        CCR_MUX_OFFSET:      rdata_nxt = mux_r;
        CCR_CTRL_OFFSET:     rdata_nxt = {on_r, sync2_r, rise_edge_flag_r,
                                          fall_edge_flag_r, hyst_r};
        CCR_IRQ_STAT_OFFSET: rdata_nxt = {6'h00, stat_r};
        CCR_IRQ_EN_OFFSET:   rdata_nxt = {6'h00, irq_en_r};
        default:             rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code 11 selects a reserved pin on the small package; software keeps off.
  assign inverting_onehot_out =
    4'h1 << mux_r[CCR_INV_LSB +: 2];
  assign noninverting_onehot_out =
    4'h1 << mux_r[CCR_NONINV_LSB +: 2];
  assign response_speed_select_out = mode_r[CCR_SPEED_LSB +: 2];
  assign comparator_on_out = on_r;
  assign cmp_pin_out = sync2_r;
  assign irq_out = (rise_edge_flag_r & mode_r[CCR_RISE_BIT]) |
                   (fall_edge_flag_r & mode_r[CCR_FALL_BIT]);
  assign ext_irq_out = |(stat_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////////
  irq_rise_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (rise_edge_flag_r && mode_r[5]) |-> irq_out)
    else $error("rising irq missing");
  irq_fall_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (fall_edge_flag_r && mode_r[4]) |-> irq_out)
    else $error("falling irq missing");
  irq_cause_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    irq_out |-> ((rise_edge_flag_r && mode_r[5]) ||
                 (fall_edge_flag_r && mode_r[4])))
    else $error("spurious irq");
  rise_set_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (sync2_r && !prev_r) |=> rise_edge_flag_r)
    else $error("rising flag not set");
  fall_set_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (!sync2_r && prev_r) |=> fall_edge_flag_r)
    else $error("falling flag not set");
  flag_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (rise_edge_flag_r && !wr_ctrl) |=> rise_edge_flag_r)
    else $error("rising flag dropped");
  off_low_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !on_r [*2] |=> !cmp_pin_out)
    else $error("output not low when off");
  unused_zero_a: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in)
    ((mode_r & 8'hcc) == 8'h00) && ((mux_r & 8'hcc) == 8'h00))
    else $error("unused bits set");
  mux_sel_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    inverting_onehot_out[mux_r[5:4]] &&
    noninverting_onehot_out[mux_r[1:0]])
    else $error("pin select wrong");
  speed_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (wr_in && addr_in == 8'h9c) |=>
      response_speed_select_out == $past(wdata_in[1:0]))
    else $error("speed field not updated");

  // Read path, stored fields and the flag life cycle.
  rd_idle_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !rd_in |=> (rdata_out == 8'h00))
    else $error("read data not idle");

  rd_mode_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (rd_in && (addr_in == CCR_MODE_OFFSET)) |=>
      (rdata_out == $past(mode_r)))
    else $error("mode read wrong");

  rd_mux_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (rd_in && (addr_in == CCR_MUX_OFFSET)) |=>
      (rdata_out == $past(mux_r)))
    else $error("select read wrong");

  rd_unused_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (rd_in && ((addr_in == CCR_MODE_OFFSET) ||
               (addr_in == CCR_MUX_OFFSET))) |=>
      ((rdata_out & 8'hcc) == 8'h00))
    else $error("unused bits read set");

  mode_wr_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    wr_mode |=> (mode_r == ($past(wdata_in) & CCR_MODE_MASK)))
    else $error("mode write wrong");

  mux_wr_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    wr_mux |=> (mux_r == ($past(wdata_in) & CCR_MUX_MASK)))
    else $error("select write wrong");

  mode_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !wr_mode |=> $stable(mode_r))
    else $error("mode changed unwritten");

  mux_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !wr_mux |=> $stable(mux_r))
    else $error("select changed unwritten");

  pin_onehot_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    $onehot(inverting_onehot_out) && $onehot(noninverting_onehot_out))
    else $error("pin select not one-hot");

  rise_gate_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (!mode_r[CCR_RISE_BIT] &&
     !(fall_edge_flag_r && mode_r[CCR_FALL_BIT])) |-> !irq_out)
    else $error("rising irq not gated");

  fall_gate_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (!mode_r[CCR_FALL_BIT] &&
     !(rise_edge_flag_r && mode_r[CCR_RISE_BIT])) |-> !irq_out)
    else $error("falling irq not gated");

  irq_idle_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (!rise_edge_flag_r && !fall_edge_flag_r) |-> !irq_out)
    else $error("irq without flag");

  fall_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (fall_edge_flag_r && !wr_ctrl) |=> fall_edge_flag_r)
    else $error("falling flag dropped");

  rise_clr_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (rise_edge_flag_r && wr_ctrl && !wdata_in[CCR_RISE_BIT] &&
     !rise_ev) |=> !rise_edge_flag_r)
    else $error("rising flag not cleared");

  fall_clr_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (fall_edge_flag_r && wr_ctrl && !wdata_in[CCR_FALL_BIT] &&
     !fall_ev) |=> !fall_edge_flag_r)
    else $error("falling flag not cleared");

  rise_cause_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (!rise_edge_flag_r && !rise_ev) |=> !rise_edge_flag_r)
    else $error("rising flag without edge");

  fall_cause_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (!fall_edge_flag_r && !fall_ev) |=> !fall_edge_flag_r)
    else $error("falling flag without edge");

  on_wr_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    wr_ctrl |=> (comparator_on_out == $past(wdata_in[CCR_ON_BIT])))
    else $error("enable write wrong");

  pin_on_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    cmp_pin_out |-> $past(on_r))
    else $error("pin high while off");

endmodule : ccr_comparator1_config_regs
`default_nettype wire

// ---- sim/ccr_comparator1_config_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccr_comparator1_config_regs_tb;
  import ccr_pkg::*;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, raw = 0, rd_d = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
  logic [3:0] inv, ninv;
  logic [1:0] spd;
  logic       on, pin, irq, xirq;
  logic [7:0] exp_q[$];
  int         error_cnt = 0, n_compared = 0, cyc = 0, seed = 8984;
  ccr_comparator1_config_regs dut_u (.sys_clk_in(clk), .sys_rst_in(rst),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .cmp_raw_in(raw), .comparator_on_out(on),
    .inverting_onehot_out(inv), .noninverting_onehot_out(ninv),
    .response_speed_select_out(spd), .cmp_pin_out(pin), .irq_out(irq),
    .ext_irq_out(xirq));
  initial begin
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] e);
    n_compared++;
    if (got !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, e);
    end
  endtask : chk
  task final_report;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  // Five edges cover the synchroniser, the edge detector and the flag.
  task settle;
    repeat (5) @(posedge clk);
    #1;
  endtask : settle
  // Read data is only valid in the single cycle after the strobe.
  always @(posedge clk) begin
    rd_d <= rd;
    cyc  <= cyc + 1;
    if (rd_d) chk(rdata, exp_q.pop_front());
    if (cyc == 4000) begin
      error_cnt++;
      final_report;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_reg(CCR_MODE_OFFSET, CCR_MODE_RESET);
    rd_reg(CCR_MUX_OFFSET, CCR_MUX_RESET);
    chk(spd, 8'h02);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      v[5:4] = i[1:0];
      v[1:0] = 2'(3 - i);
      wr_reg(CCR_MUX_OFFSET, v);
      chk(inv, 8'h01 << i);
      chk(ninv, 8'h01 << (3 - i));
      rd_reg(CCR_MUX_OFFSET, v & 8'h33);
      v = 8'($random(seed));
      v[1:0] = i[1:0];
      wr_reg(CCR_MODE_OFFSET, v);
      chk(spd, i[1:0]);
      rd_reg(CCR_MODE_OFFSET, v & 8'h33);
    end
    rd_reg(8'h55, 8'h00);
    $display("test select and mode done");
    wr_reg(CCR_CTRL_OFFSET, 8'h80);
    chk(on, 8'h01);
    wr_reg(CCR_MODE_OFFSET, 8'h20);
    wr_reg(CCR_IRQ_EN_OFFSET, 8'h03);
    raw <= 1'b1;
    settle;
    chk(irq, 8'h01);
    chk(pin, 8'h01);
    raw <= 1'b0;
    settle;
    chk(irq, 8'h01);
    rd_reg(CCR_CTRL_OFFSET, 8'hb0);
    wr_reg(CCR_CTRL_OFFSET, 8'h90);
    settle;
    chk(irq, 8'h00);
    wr_reg(CCR_MODE_OFFSET, 8'h10);
    settle;
    chk(irq, 8'h01);
    wr_reg(CCR_CTRL_OFFSET, 8'h80);
    settle;
    chk(irq, 8'h00);
    chk(xirq, 8'h01);
    rd_reg(CCR_IRQ_STAT_OFFSET, 8'h03);
    wr_reg(CCR_IRQ_EN_OFFSET, 8'h00);
    settle;
    chk(xirq, 8'h00);
    wr_reg(CCR_IRQ_CLR_OFFSET, 8'h03);
    wr_reg(CCR_IRQ_EN_OFFSET, 8'h03);
    rd_reg(CCR_IRQ_STAT_OFFSET, 8'h00);
    settle;
    chk(xirq, 8'h00);
    $display("test edges and interrupts done");
    wr_reg(CCR_CTRL_OFFSET, 8'h0a);
    raw <= 1'b1;
    settle;
    chk(pin, 8'h00);
    chk(on, 8'h00);
    rd_reg(CCR_CTRL_OFFSET, 8'h0a);
    $display("test comparator off done");
    final_report;
  end
endmodule : ccr_comparator1_config_regs_tb
`default_nettype wire
